/* logic/tpo_pkg.sv */
// Shared types and constants for the pixel output formatter
// Functional notes
// R1: One-pixel mode: even and odd green go out in turn on even bus 15:8.
// R2: Two-pixel mode: even bus 15:8 carries only the even pixel green.
// R3: One-pixel mode: even and odd red go out in turn on even bus 23:16.
// R4: Two-pixel mode: even bus 23:16 carries only the even pixel red.
// R5: Two-pixel mode: odd bus 7:0 carries the odd pixel blue.
// R6: Two-pixel mode: odd bus 15:8 carries the odd pixel green.
// R7: Two-pixel mode: odd bus 23:16 carries the odd pixel red.
// R8: One-pixel mode: all odd bus bits are held low; a stale odd value clears with the next word.
// R9: Both buses change only in step with the output pixel clock.
// R10: Lane zero: blue when active, horizontal and vertical sync in blanking.
// R11: Lane one: green when active, first auxiliary control bit in blanking.
// R12: One-pixel mode: one pixel per clock, even first; first pixel of a line is even.
// R13: Select high means two pixels per clock, low means one.
// R14: Lane two: red when active, second auxiliary control bit in blanking.
// R15: Output clock period is one link pixel time, or two in two-pixel mode.
// R16: Even bus 7:0 carries blue: both samples in one-pixel mode, even only otherwise.
// R17: In each colour field the lowest bit is the least significant.
package tpo_pkg;

	localparam int COLOR_W = 8;
	localparam int PIX_W = 24;
	localparam int BLUE_LSB = 0;
	localparam int GREEN_LSB = 8;
	localparam int RED_LSB = 16;
	localparam int SYNC_STAGES = 2;
	localparam int BUF_DEPTH = 2;
	localparam int CLK_PERIOD_NS = 20;
	// Control code bit positions within a lane
	localparam int CTL_C0 = 0;
	localparam int CTL_C1 = 1;
	localparam int CTL_W = 2;

	typedef struct packed {
		logic [CTL_W-1:0] ctl;
		logic [COLOR_W-1:0] data;
	} tpo_lane_t;

	// Declared red first so blue lands in bits 7:0 and each field keeps its LSB low
	typedef struct packed {
		logic [COLOR_W-1:0] red;
		logic [COLOR_W-1:0] green;
		logic [COLOR_W-1:0] blue;
	} tpo_pixel_t;

	typedef struct packed {
		logic de;
		logic hsync;
		logic vsync;
		logic aux_control_bit_one;
		logic aux_control_bit_two;
		logic two_pix;
		tpo_pixel_t even;
		tpo_pixel_t odd;
	} tpo_word_t;

	localparam int WORD_W = $bits(tpo_word_t);

	typedef enum {
		TPO_ST_LOAD,
		TPO_ST_RISE
	} tpo_out_state_t;

endpackage

/* logic/tpo_sync.sv */
// Two-flop synchroniser for levels and toggles
`timescale 1ns/10ps
module tpo_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// The first stage is read by the second stage only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;

endmodule

/* logic/tpo_buf.sv */
// Small FIFO with valid/ready on both sides
`timescale 1ns/10ps
module tpo_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready_o = (cnt_r != CW'(DEPTH));
	assign out_valid_o = (cnt_r != '0);
	assign out_data_o = mem_r[rd_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_comb begin
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + PW'(1);
		end
		if (pop) begin
			rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + PW'(1);
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + CW'(1);
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - CW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage carries no reset; it is only read while counted valid
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wr_r] <= in_data_i;
		end
	end

endmodule

/* logic/tpo_formatter.sv */
// Pixel output formatter: lane routing, pixel pairing, crossing and output bus drive
`timescale 1ns/10ps
module tpo_formatter (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic link_clock_pair_i,
	input wire logic link_de_i,
	input wire tpo_pkg::tpo_lane_t link_lane_zero_i,
	input wire tpo_pkg::tpo_lane_t link_lane_one_i,
	input wire tpo_pkg::tpo_lane_t link_lane_two_i,
	input wire logic pixels_per_clock_select_i,
	input wire logic panel_ready_i,
	output logic [tpo_pkg::PIX_W-1:0] even_pixel_bus_o,
	output logic [tpo_pkg::PIX_W-1:0] odd_pixel_bus_o,
	output logic output_pixel_clock_o,
	output logic de_o,
	output logic hsync_o,
	output logic vsync_o,
	output logic aux_control_bit_one_o,
	output logic aux_control_bit_two_o,
	output logic overrun_o
);

	// Route the three lanes into one sample: pixel when active, control codes when blank
	function automatic tpo_pkg::tpo_word_t lanes_to_sample(
		input logic de,
		input tpo_pkg::tpo_lane_t l0,
		input tpo_pkg::tpo_lane_t l1,
		input tpo_pkg::tpo_lane_t l2,
		input logic two
	);
		tpo_pkg::tpo_word_t s;
		s = '0;
		s.de = de;
		s.two_pix = two;
		if (de) begin
			s.even.blue = l0.data; // R10
			s.even.green = l1.data; // R11
			s.even.red = l2.data; // R14
		end else begin
			// Colour fields stay zero in blanking, so the panel never sees stale pixels
			s.hsync = l0.ctl[tpo_pkg::CTL_C0]; // R10
			s.vsync = l0.ctl[tpo_pkg::CTL_C1]; // R10
			s.aux_control_bit_one = l1.ctl[tpo_pkg::CTL_C0]; // R11
			s.aux_control_bit_two = l2.ctl[tpo_pkg::CTL_C0]; // R14
		end
		return s;
	endfunction

	// A held half sent on its own: odd half zero, still marked as a two-pixel word
	function automatic tpo_pkg::tpo_word_t lone_half(
		input tpo_pkg::tpo_word_t h
	);
		tpo_pkg::tpo_word_t w;
		w = h;
		w.two_pix = 1'b1;
		w.odd = '0;
		return w;
	endfunction

	// Link domain reset: asserted at once, released on the link clock
	logic link_rst_b;

	tpo_sync #(.W(1)) u_link_rst (
		.clk_i(link_clock_pair_i),
		.rst_b_i(rst_b_i),
		.d_i(1'b1),
		.q_o(link_rst_b)
	);

	logic mode_l;
	logic ack_l;
	logic ack_r;

	tpo_sync #(.W(2)) u_link_in (
		.clk_i(link_clock_pair_i),
		.rst_b_i(link_rst_b),
		.d_i({pixels_per_clock_select_i, ack_r}),
		.q_o({mode_l, ack_l})
	);

	// Link side: pair pixels, hold one word until the output side acknowledges it
	tpo_pkg::tpo_word_t cur;
	tpo_pkg::tpo_word_t cand;
	tpo_pkg::tpo_word_t hold_r, hold_nxt;
	tpo_pkg::tpo_word_t word_r, word_nxt;
	logic slot_r, slot_nxt;
	logic req_r, req_nxt;
	logic drop_r, drop_nxt;
	logic have;

	always_comb begin
		cur = lanes_to_sample(link_de_i, link_lane_zero_i, link_lane_one_i, link_lane_two_i, mode_l);
		hold_nxt = hold_r;
		slot_nxt = slot_r;
		word_nxt = word_r;
		req_nxt = req_r;
		drop_nxt = drop_r;
		cand = cur;
		have = 1'b0;
		if (!mode_l) begin
			// One sample per word, odd half stays zero
			have = 1'b1; // R12
			slot_nxt = 1'b0;
		end else if (!slot_r) begin
			hold_nxt = cur;
			slot_nxt = 1'b1;
		end else if (cur.de == hold_r.de) begin
			cand = lone_half(hold_r);
			cand.odd = cur.even; // R5 R6 R7
			have = 1'b1;
			slot_nxt = 1'b0;
		end else begin
			// Line edge inside a pair: send the lone half so the next line starts even
			cand = lone_half(hold_r); // R12
			hold_nxt = cur;
			have = 1'b1;
		end
		if (have) begin
			// Toggle handshake: word_r may change only once its last request was acknowledged
			if (req_r == ack_l) begin
				word_nxt = cand;
				req_nxt = ~req_r;
			end else begin
				// A TMDS source cannot be stalled, so a busy crossing drops the word
				drop_nxt = ~drop_r;
			end
		end
	end

	always_ff @(posedge link_clock_pair_i or negedge link_rst_b) begin
		if (!link_rst_b) begin
			hold_r <= '0;
			slot_r <= 1'b0;
			word_r <= '0;
			req_r <= 1'b0;
			drop_r <= 1'b0;
		end else begin
			hold_r <= hold_nxt;
			slot_r <= slot_nxt;
			word_r <= word_nxt;
			req_r <= req_nxt;
			drop_r <= drop_nxt;
		end
	end

	// Output side: toggle handshake in, buffer, then drive the buses
	logic req_c;
	logic drop_c;
	logic panel_rdy_c;
	logic mode_c;

	// Request and drop are toggles, so one level crossing per bit is safe for them
	tpo_sync #(.W(3)) u_sys_in (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({req_r, drop_r, panel_ready_i}),
		.q_o({req_c, drop_c, panel_rdy_c})
	);

	// The select is seen here too, so a late two-pixel word cannot reach the odd bus
	tpo_sync #(.W(1)) u_sys_mode (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i(pixels_per_clock_select_i),
		.q_o(mode_c)
	);

	logic push_valid;
	logic push_ready;
	logic pop_valid;
	logic pop_ready;
	logic [tpo_pkg::WORD_W-1:0] pop_data;
	tpo_pkg::tpo_word_t pw;
	logic ack_nxt;

	// The link word is stable from the request toggle until the acknowledge returns
	assign push_valid = (req_c != ack_r);

	// Two entries ride out the lag of the panel ready synchroniser
	tpo_buf #(.W(tpo_pkg::WORD_W), .DEPTH(tpo_pkg::BUF_DEPTH)) u_buf (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(push_valid),
		.in_ready_o(push_ready),
		.in_data_i(word_r),
		.out_valid_o(pop_valid),
		.out_ready_i(pop_ready),
		.out_data_o(pop_data)
	);

	// The buffer stores raw bits; the struct view is restored here
	assign pw = tpo_pkg::tpo_word_t'(pop_data);

	logic drop_seen_r, drop_seen_nxt;
	logic overrun_r, overrun_nxt;

	always_comb begin
		ack_nxt = ack_r;
		// Acknowledge only once stored, so a full buffer holds the link side off
		if (push_valid && push_ready) begin
			ack_nxt = req_c;
		end
		drop_seen_nxt = drop_c;
		// Sticky until reset: a lost word cannot be recovered downstream
		overrun_nxt = overrun_r || (drop_c != drop_seen_r);
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_r <= 1'b0;
			drop_seen_r <= 1'b0;
			overrun_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
			drop_seen_r <= drop_seen_nxt;
			overrun_r <= overrun_nxt;
		end
	end

	// Bus update with the clock low, rising edge one cycle later marks the sample point
	tpo_pkg::tpo_out_state_t st_r, st_nxt;
	tpo_pkg::tpo_pixel_t even_r, even_nxt;
	tpo_pkg::tpo_pixel_t odd_r, odd_nxt;
	logic pclk_r, pclk_nxt;
	logic de_r, de_nxt;
	logic hs_r, hs_nxt;
	logic vs_r, vs_nxt;
	logic c1_r, c1_nxt;
	logic c2_r, c2_nxt;

	// Ready arrives two cycles late; the buffer absorbs the words that land meanwhile
	assign pop_ready = (st_r == tpo_pkg::TPO_ST_LOAD) && panel_rdy_c;

	always_comb begin
		st_nxt = st_r;
		even_nxt = even_r;
		odd_nxt = odd_r;
		pclk_nxt = pclk_r;
		de_nxt = de_r;
		hs_nxt = hs_r;
		vs_nxt = vs_r;
		c1_nxt = c1_r;
		c2_nxt = c2_r;
		case (st_r)
			tpo_pkg::TPO_ST_LOAD: begin
				if (pop_valid && pop_ready) begin
					even_nxt = pw.even; // R1 R2 R3 R4 R16 R17
					// Limitation: a stale odd value clears with the next word, not at the select change
					odd_nxt = (pw.two_pix && mode_c) ? pw.odd : '0; // R8 R13
					de_nxt = pw.de;
					hs_nxt = pw.hsync;
					vs_nxt = pw.vsync;
					c1_nxt = pw.aux_control_bit_one;
					c2_nxt = pw.aux_control_bit_two;
					pclk_nxt = 1'b0; // R9
					st_nxt = tpo_pkg::TPO_ST_RISE;
				end
			end
			tpo_pkg::TPO_ST_RISE: begin
				// One rising edge per word: paired words halve the edge rate
				pclk_nxt = 1'b1; // R9 R15
				st_nxt = tpo_pkg::TPO_ST_LOAD;
			end
			default: begin
				st_nxt = tpo_pkg::TPO_ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_r <= tpo_pkg::TPO_ST_LOAD;
			even_r <= '0;
			odd_r <= '0;
			pclk_r <= 1'b0;
			de_r <= 1'b0;
			hs_r <= 1'b0;
			vs_r <= 1'b0;
			c1_r <= 1'b0;
			c2_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			even_r <= even_nxt;
			odd_r <= odd_nxt;
			pclk_r <= pclk_nxt;
			de_r <= de_nxt;
			hs_r <= hs_nxt;
			vs_r <= vs_nxt;
			c1_r <= c1_nxt;
			c2_r <= c2_nxt;
		end
	end

	// All outputs come straight from registers, so the panel sees no decode glitches
	assign even_pixel_bus_o = even_r;
	assign odd_pixel_bus_o = odd_r;
	assign output_pixel_clock_o = pclk_r;
	assign de_o = de_r;
	assign hsync_o = hs_r;
	assign vsync_o = vs_r;
	assign aux_control_bit_one_o = c1_r;
	assign aux_control_bit_two_o = c2_r;
	assign overrun_o = overrun_r;

endmodule

/* test/tpo_link_model.sv */
// Link transmitter model driving decoded lanes on a link clock that stops between bursts
`timescale 1ns/10ps
module tpo_link_model (
	output logic link_clk_o,
	output logic de_o,
	output tpo_pkg::tpo_lane_t lane0_o,
	output tpo_pkg::tpo_lane_t lane1_o,
	output tpo_pkg::tpo_lane_t lane2_o
);
	initial begin
		link_clk_o = 1'b0;
		de_o = 1'b0;
		lane0_o = '0;
		lane1_o = '0;
		lane2_o = '0;
	end
	// Samples alternate even/odd; ctl is {hsync, vsync, aux one, aux two}
	task automatic burst(input int n, input logic de, input logic [3:0] ctl, input logic [23:0] pe,
		input logic [23:0] po);
		logic [23:0] px;
		#1.7;
		for (int i = 0; i < n; i++) begin
			px = i[0] ? po : pe;
			de_o = de;
			lane0_o = '{de ? 2'h0 : {ctl[2], ctl[3]}, px[7:0]};
			lane1_o = '{de ? 2'h0 : {1'b0, ctl[1]}, px[15:8]};
			lane2_o = '{de ? 2'h0 : {1'b0, ctl[0]}, px[23:16]};
			#3 link_clk_o = 1'b1;
			#3 link_clk_o = 1'b0;
		end
	endtask
endmodule

/* test/tpo_formatter_asserts.sv */
// Port checks for the pixel output formatter
`timescale 1ns/10ps
module tpo_formatter_asserts (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pixels_per_clock_select_i,
	input wire logic panel_ready_i,
	input wire logic [tpo_pkg::PIX_W-1:0] even_pixel_bus_o,
	input wire logic [tpo_pkg::PIX_W-1:0] odd_pixel_bus_o,
	input wire logic output_pixel_clock_o,
	input wire logic de_o,
	input wire logic hsync_o,
	input wire logic vsync_o,
	input wire logic aux_control_bit_one_o,
	input wire logic aux_control_bit_two_o,
	input wire logic overrun_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic [5:0] low_cnt_r;
	logic [5:0] low_cnt_nxt;
	logic [3:0] ctl_w;
	assign ctl_w = {hsync_o, vsync_o, aux_control_bit_one_o, aux_control_bit_two_o};
	// Long settle so words still in flight across a mode change are not judged
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		if (pixels_per_clock_select_i)
			low_cnt_nxt = 6'h00;
		else if (low_cnt_r != 6'h3F)
			low_cnt_nxt = low_cnt_r + 6'h01;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			low_cnt_r <= 6'h00;
		else
			low_cnt_r <= low_cnt_nxt;
	end
	sequence s_strobe;
		!output_pixel_clock_o ##1 output_pixel_clock_o;
	endsequence
	a_bus_on_strobe: assert property (!$stable({even_pixel_bus_o, odd_pixel_bus_o}) |-> s_strobe)
		else $error("pixel bus moved off the strobe");
	a_ctl_on_strobe: assert property (!$stable({ctl_w, de_o}) |-> s_strobe)
		else $error("control outputs moved off the strobe");
	a_strobe_low_one: assert property ($fell(output_pixel_clock_o) |=> output_pixel_clock_o)
		else $error("strobe low not one cycle");
	a_odd_low_one: assert property (low_cnt_r == 6'h3F |-> odd_pixel_bus_o == 24'h000000)
		else $error("odd bus not low in one pixel mode");
	a_blank_bus_zero: assert property (!de_o |-> even_pixel_bus_o == 24'h000000 && odd_pixel_bus_o == 24'h000000)
		else $error("pixel bus not zero in blanking");
	a_active_ctl_zero: assert property (de_o |-> ctl_w == 4'h0)
		else $error("control outputs set in active display");
	a_stall_no_strobe: assert property ($rose(output_pixel_clock_o) |-> $past(panel_ready_i, 2)
		|| $past(panel_ready_i, 3) || $past(panel_ready_i, 4) || $past(panel_ready_i, 5)
		|| $past(panel_ready_i, 6)) else $error("strobe while panel stalled");
	a_overrun_sticky: assert property (overrun_o |=> overrun_o) else $error("overrun flag cleared");
	a_reset_quiet: assert property ($rose(rst_b_i) |-> !output_pixel_clock_o && even_pixel_bus_o == 24'h000000)
		else $error("outputs active at reset release");
endmodule
bind tpo_formatter tpo_formatter_asserts u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.pixels_per_clock_select_i(pixels_per_clock_select_i), .panel_ready_i(panel_ready_i),
	.even_pixel_bus_o(even_pixel_bus_o), .odd_pixel_bus_o(odd_pixel_bus_o),
	.output_pixel_clock_o(output_pixel_clock_o), .de_o(de_o), .hsync_o(hsync_o), .vsync_o(vsync_o),
	.aux_control_bit_one_o(aux_control_bit_one_o), .aux_control_bit_two_o(aux_control_bit_two_o),
	.overrun_o(overrun_o));

/* test/testbench.sv */
// Self-checking bench for the pixel output formatter
`timescale 1ns/10ps
module testbench;
	logic clk_i;
	logic rst_b_i;
	logic sel;
	logic rdy;
	logic lclk;
	logic lde;
	tpo_pkg::tpo_lane_t l0, l1, l2;
	logic [23:0] even, odd;
	logic pclk, de, hs, vs, a1, a2, ovr;
	int miscompares;
	int cmp_count;
	int words;
	logic one_mode;
	logic pclk_q = 1'b0;
	logic [23:0] exp_e, exp_o;
	logic [3:0] exp_ctl;
	initial begin
		clk_i = 1'b0;
		forever #(tpo_pkg::CLK_PERIOD_NS / 2) clk_i = ~clk_i;
	end
	tpo_link_model LNK (.link_clk_o(lclk), .de_o(lde), .lane0_o(l0), .lane1_o(l1), .lane2_o(l2));
	tpo_formatter DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .link_clock_pair_i(lclk), .link_de_i(lde),
		.link_lane_zero_i(l0), .link_lane_one_i(l1), .link_lane_two_i(l2), .pixels_per_clock_select_i(sel),
		.panel_ready_i(rdy), .even_pixel_bus_o(even), .odd_pixel_bus_o(odd), .output_pixel_clock_o(pclk),
		.de_o(de), .hsync_o(hs), .vsync_o(vs), .aux_control_bit_one_o(a1), .aux_control_bit_two_o(a2),
		.overrun_o(ovr));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("Compares %0d, miscompares %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Link words drop under load, so every word is judged against the burst's fixed content
	always @(negedge clk_i) begin
		pclk_q <= pclk;
		if (rst_b_i && pclk && !pclk_q) begin
			words++;
			if (!de)
				check({hs, vs, a1, a2}, exp_ctl);
			else if (one_mode) begin
				check(even === exp_e || even === exp_o, 1'b1);
				check(odd, 24'h0);
			end else begin
				check(even, exp_e);
				check(odd, exp_o);
			end
		end
	end
	task automatic drain;
		repeat (60) @(negedge clk_i);
	endtask
	task automatic run(input int n, input logic d, input logic [3:0] c);
		words = 0;
		LNK.burst(n, d, c, exp_e, exp_o);
		drain();
		check(words > 0, 1'b1);
	endtask
	task automatic s_two_pixel;
		exp_ctl = 4'h5;
		exp_e = 24'h3C55A1;
		// Odd blank count leaves a half held at the line start, which must go out alone
		run(21, 1'b0, 4'h5);
		exp_e = 24'h8142F1;
		exp_o = 24'h07E03C;
		run(40, 1'b1, 4'h0);
	endtask
	task automatic s_stall;
		rdy = 1'b0;
		exp_e = 24'h10FE01;
		exp_o = 24'hC3A580;
		words = 0;
		LNK.burst(40, 1'b1, 4'h0, exp_e, exp_o);
		drain();
		check(words, 0);
		rdy = 1'b1;
		drain();
		check(words > 0, 1'b1);
		check(ovr, 1'b1);
	endtask
	task automatic s_one_pixel;
		sel = 1'b0;
		exp_ctl = 4'hA;
		exp_e = 24'h5A5A5A;
		run(21, 1'b0, 4'hA);
		one_mode = 1'b1;
		exp_e = 24'h814218;
		exp_o = 24'h7EBD01;
		run(41, 1'b1, 4'h0);
	endtask
	initial begin
		#50us;
		miscompares++;
		end_sim();
	end
	initial begin
		rst_b_i = 1'b0;
		sel = 1'b1;
		rdy = 1'b1;
		one_mode = 1'b0;
		exp_ctl = 4'h0;
		exp_e = 24'h0;
		exp_o = 24'h0;
		LNK.burst(5, 1'b0, 4'h0, 24'h0, 24'h0);
		repeat (20) @(negedge clk_i);
		rst_b_i = 1'b1;
		run(4, 1'b0, 4'h0);
		s_two_pixel();
		s_stall();
		s_one_pixel();
		end_sim();
	end
endmodule
